//--- flow_ctrl.sv
// conversion flow control: restart, trigger, abort and list swap sequencing
// assumes bus-side request bits are one-cycle pulses on CLK_I; wake pin async
`timescale 1ns/1ps
`default_nettype none
module flow_ctrl #(
  parameter int AW = flow_ctrl_pkg::LIST_AW
) (
  input  wire logic          CLK_I,
  input  wire logic          RST_I,
  input  wire logic [1:0]    FLOW_ACCESS_CONFIG_FIELD_I,
  input  wire logic          TRIGGER_MODE_I,
  input  wire logic          DOUBLE_BUF_I,
  input  wire logic          AUTO_RESTART_ENABLE_I,
  input  wire logic          WAIT_STOP_SELECT_I,
  input  wire logic          STOP_MODE_I,
  input  wire logic          WAIT_MODE_I,
  input  wire logic          BUS_RESTART_I,
  input  wire logic          BUS_TRIGGER_I,
  input  wire logic          BUS_ABORT_I,
  input  wire logic          BUS_LOAD_OK_I,
  input  wire logic          INT_RESTART_I,
  input  wire logic          INT_TRIGGER_I,
  input  wire logic          INT_ABORT_I,
  input  wire logic          INT_LOAD_OK_I,
  input  wire logic          ERR_CLEAR_I,
  input  wire logic          CMD_WE_I,
  input  wire logic          CMD_WR_LIST_I,
  input  wire logic [AW-1:0] CMD_WADDR_I,
  input  wire logic [1:0]    CMD_WDATA_I,
  output logic               RESTART_REQUEST_BIT_O,
  output logic               TRIGGER_REQUEST_BIT_O,
  output logic               SEQUENCE_ABORT_BIT_O,
  output logic               LIST_SWAP_LOAD_OK_O,
  output logic               EARLY_TRIGGER_ERROR_FLAG_O,
  output logic               RESTART_WHILE_BUSY_ERROR_FLAG_O,
  output logic               BUSY_O,
  output logic               ACTIVE_LIST_O,
  output logic               SAMPLE_START_O,
  output logic               END_OF_LIST_O
);
  typedef struct packed {
    flow_ctrl_pkg::state_t state;
    logic          restart_request_bit;
    logic          trigger_request_bit;
    logic          sequence_abort_bit;
    logic          list_swap_load_ok;
    logic          early_trigger_error_flag;
    logic          restart_while_busy_error_flag;
    logic          active;
    logic          busy;
    logic          sample;
    logic          eol;
    logic [AW-1:0] ptr;
    logic [7:0]    cnt;
    logic          lp_pending;
    logic [2:0]    lp_sync;
  } st_t;

  st_t        s_r;
  st_t        s_nxt;
  logic [1:0] cmd;
  logic       restart;
  logic       trigger;
  logic       abort;
  logic       load_ok;
  logic       in_lp;
  logic       lp_exit;
  logic       bus_en;
  logic       int_en;

  // request source select
  assign bus_en  = FLOW_ACCESS_CONFIG_FIELD_I[1];
  assign int_en  = FLOW_ACCESS_CONFIG_FIELD_I[0];
  assign restart = (bus_en & BUS_RESTART_I) | (int_en & INT_RESTART_I);
  assign trigger = (bus_en & BUS_TRIGGER_I) | (int_en & INT_TRIGGER_I);
  assign abort   = (bus_en & BUS_ABORT_I) | (int_en & INT_ABORT_I);
  assign load_ok = (bus_en & BUS_LOAD_OK_I) | (int_en & INT_LOAD_OK_I);

  // low power level synchronised, exit when stages 2 and 3 agree low
  assign in_lp   = STOP_MODE_I | (WAIT_MODE_I & WAIT_STOP_SELECT_I);
  assign lp_exit = s_r.lp_pending & ~s_r.lp_sync[1] & ~s_r.lp_sync[2];

  cmd_list_mem #(.AW(AW)) u_mem (
    .clk_i     (CLK_I),
    .we_i      (CMD_WE_I),
    .wr_list_i (CMD_WR_LIST_I),
    .waddr_i   (CMD_WADDR_I),
    .wdata_i   (CMD_WDATA_I),
    .rd_list_i (s_r.active),
    .raddr_i   (s_r.ptr),
    .rdata_o   (cmd)
  );

  always_comb begin
    s_nxt         = s_r;
    s_nxt.sample  = 1'b0;
    s_nxt.eol     = 1'b0;
    s_nxt.lp_sync = {s_r.lp_sync[1:0], in_lp};
    if (s_r.lp_sync[1] & s_r.lp_sync[2] & AUTO_RESTART_ENABLE_I) begin
      s_nxt.lp_pending = 1'b1;
    end
    if (ERR_CLEAR_I) begin
      s_nxt.early_trigger_error_flag  = 1'b0;
      s_nxt.restart_while_busy_error_flag = 1'b0;
    end
    if (abort) begin
      s_nxt.sequence_abort_bit = 1'b1;
    end
    // in restart mode, trigger during restart loading is an ordering error
    if (trigger & (s_r.restart_request_bit | restart) & ~TRIGGER_MODE_I) begin
      s_nxt.early_trigger_error_flag = 1'b1;
    end else if (trigger) begin
      s_nxt.trigger_request_bit = 1'b1;
    end
    if (restart | lp_exit) begin
      s_nxt.restart_request_bit       = 1'b1;
      s_nxt.lp_pending = 1'b0;
      if (load_ok) begin
        s_nxt.list_swap_load_ok = 1'b1;
      end
      // busy restart without abort forces abort
      if (s_r.busy & ~s_r.sequence_abort_bit & ~abort) begin
        s_nxt.sequence_abort_bit      = 1'b1;
        s_nxt.restart_while_busy_error_flag = 1'b1;
      end
    end
    case (s_r.state)
      flow_ctrl_pkg::ST_IDLE, flow_ctrl_pkg::ST_WAIT_TRIGGER_REQUEST_BIT: begin
        if (s_nxt.sequence_abort_bit) begin
          s_nxt.state = flow_ctrl_pkg::ST_ABORT;
        end else if (s_nxt.restart_request_bit) begin
          s_nxt.state = flow_ctrl_pkg::ST_LOAD;
          s_nxt.cnt   = 8'(flow_ctrl_pkg::LOAD_CYC);
        end else if (s_r.trigger_request_bit & (s_r.state == flow_ctrl_pkg::ST_WAIT_TRIGGER_REQUEST_BIT)) begin
          s_nxt.trigger_request_bit  = 1'b0;
          s_nxt.busy  = 1'b1;
          s_nxt.state = flow_ctrl_pkg::ST_DELAY;
          s_nxt.cnt   = 8'(flow_ctrl_pkg::TRIGGER_REQUEST_BIT_LAT_CYC);
        end
      end
      flow_ctrl_pkg::ST_ABORT: begin
        // idle now; abort done
        s_nxt.sequence_abort_bit  = 1'b0;
        s_nxt.busy  = 1'b0;
        s_nxt.trigger_request_bit  = 1'b0;
        s_nxt.state = s_r.restart_request_bit ? flow_ctrl_pkg::ST_IDLE : flow_ctrl_pkg::ST_IDLE;
      end
      flow_ctrl_pkg::ST_LOAD: begin
        if (s_r.cnt > 8'h01) begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end else begin
          s_nxt.restart_request_bit = 1'b0;
          s_nxt.list_swap_load_ok = 1'b0;
          s_nxt.ptr  = '0;
          if (s_r.list_swap_load_ok & DOUBLE_BUF_I) begin
            s_nxt.active = ~s_r.active;
          end
          s_nxt.state = flow_ctrl_pkg::ST_WAIT_TRIGGER_REQUEST_BIT;
          if (TRIGGER_MODE_I) begin
            s_nxt.trigger_request_bit = 1'b1;
          end
        end
      end
      flow_ctrl_pkg::ST_DELAY: begin
        if (s_r.cnt > 8'h01) begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end else begin
          s_nxt.sample = 1'b1;
          s_nxt.cnt    = 8'(flow_ctrl_pkg::CONV_CYC);
          s_nxt.state  = flow_ctrl_pkg::ST_CONV;
        end
      end
      flow_ctrl_pkg::ST_CONV: begin
        if (s_r.cnt > 8'h01) begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end else begin
          s_nxt.state = flow_ctrl_pkg::ST_FETCH;
        end
      end
      flow_ctrl_pkg::ST_FETCH: begin
        s_nxt.ptr = s_r.ptr + AW'(1);
        case (cmd)
          flow_ctrl_pkg::CMD_END_SEQ: begin
            s_nxt.busy  = 1'b0;
            s_nxt.state = flow_ctrl_pkg::ST_WAIT_TRIGGER_REQUEST_BIT;
          end
          flow_ctrl_pkg::CMD_END_WRAP: begin
            s_nxt.busy  = 1'b0;
            s_nxt.eol   = 1'b1;
            s_nxt.ptr   = '0;
            s_nxt.state = flow_ctrl_pkg::ST_WAIT_TRIGGER_REQUEST_BIT;
          end
          flow_ctrl_pkg::CMD_END_LIST: begin
            s_nxt.busy  = 1'b0;
            s_nxt.eol   = 1'b1;
            s_nxt.ptr   = '0;
            s_nxt.state = flow_ctrl_pkg::ST_IDLE;
          end
          default: begin
            s_nxt.sample = 1'b1;
            s_nxt.cnt    = 8'(flow_ctrl_pkg::CONV_CYC);
            s_nxt.state  = flow_ctrl_pkg::ST_CONV;
          end
        endcase
        if (s_nxt.sequence_abort_bit) begin
          s_nxt.state = flow_ctrl_pkg::ST_ABORT;
        end
      end
      default: begin
        s_nxt.state = flow_ctrl_pkg::ST_IDLE;
      end
    endcase
    if (s_r.state inside {flow_ctrl_pkg::ST_DELAY, flow_ctrl_pkg::ST_CONV} && s_nxt.sequence_abort_bit) begin
      s_nxt.state = flow_ctrl_pkg::ST_ABORT;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RESTART_REQUEST_BIT_O           = s_r.restart_request_bit;
  assign TRIGGER_REQUEST_BIT_O           = s_r.trigger_request_bit;
  assign SEQUENCE_ABORT_BIT_O            = s_r.sequence_abort_bit;
  assign LIST_SWAP_LOAD_OK_O             = s_r.list_swap_load_ok;
  assign EARLY_TRIGGER_ERROR_FLAG_O      = s_r.early_trigger_error_flag;
  assign RESTART_WHILE_BUSY_ERROR_FLAG_O = s_r.restart_while_busy_error_flag;
  assign BUSY_O                          = s_r.busy;
  assign ACTIVE_LIST_O                   = s_r.active;
  assign SAMPLE_START_O                  = s_r.sample;
  assign END_OF_LIST_O                   = s_r.eol;
endmodule // flow_ctrl
`default_nettype wire

//--- flow_ctrl_pkg.sv
// constants and types for the conversion flow control
// assumes a single 125 MHz clock domain
// Overview of operation
// - in trigger mode each sequence of the list starts on its own trigger
// - end-of-list with select 2'b11 wraps to list top and waits for trigger
// - auto restart enabled before low power issues a restart on exit; conversion follows only in trigger mode
// - trigger mode makes every restart raise an internal trigger
// - restart mode restart gives no trigger; trigger only after restart clears
// - in restart mode, trigger before restart finished sets the early trigger error flag
// - trigger to sampling start takes a fixed number of cycles
// - single or double list buffering; restart with load ok swaps lists
// - sequence abort bit cleared by hardware once aborted and idle
// - restart while busy without abort aborts and sets busy error flag
// - flow bits reachable by bus, internal interface or both per field
package flow_ctrl_pkg;
  localparam logic [1:0] CMD_NORMAL     = 2'h0;
  localparam logic [1:0] CMD_END_SEQ    = 2'h1;
  localparam logic [1:0] CMD_END_LIST   = 2'h2;
  localparam logic [1:0] CMD_END_WRAP   = 2'h3;
  localparam logic [1:0] ACC_NONE       = 2'h0;
  localparam logic [1:0] ACC_INTERNAL   = 2'h1;
  localparam logic [1:0] ACC_BUS        = 2'h2;
  localparam logic [1:0] ACC_BOTH       = 2'h3;
  localparam int         CLK_MHZ        = 125;
  localparam int         TRIGGER_REQUEST_BIT_LAT_NS    = 16;
  localparam int         TRIGGER_REQUEST_BIT_LAT_CYC   = (TRIGGER_REQUEST_BIT_LAT_NS * CLK_MHZ + 999) / 1000;
  localparam int         LOAD_CYC       = 2;
  localparam int         CONV_CYC       = 4;
  localparam int         LIST_AW        = 4;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ABORT, ST_LOAD, ST_WAIT_TRIGGER_REQUEST_BIT, ST_DELAY, ST_CONV, ST_FETCH
  } state_t;
endpackage

//--- cmd_list_mem.sv
// two command lists held in one memory, registered read data
// assumes one clock; list index is the top address bit
`timescale 1ns/1ps
`default_nettype none
module cmd_list_mem #(
  parameter int AW = 4
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic          wr_list_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [1:0]    wdata_i,
  input  wire logic          rd_list_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [1:0]    rdata_o
);
  logic [1:0] mem [0:(2**(AW+1))-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[{wr_list_i, waddr_i}] <= wdata_i;
    end
    rdata_o <= mem[{rd_list_i, raddr_i}];
  end
endmodule // cmd_list_mem
`default_nettype wire

//--- flow_chk.sv
// checker on the flow control ports
// assumes a bind from the testbench top and one clock domain
`timescale 1ns/1ps
`default_nettype none
module flow_chk (
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic [1:0] FLOW_ACCESS_CONFIG_FIELD_I,
  input wire logic       TRIGGER_MODE_I,
  input wire logic       DOUBLE_BUF_I,
  input wire logic       BUS_RESTART_I,
  input wire logic       BUS_TRIGGER_I,
  input wire logic       BUS_ABORT_I,
  input wire logic       RESTART_REQUEST_BIT_O,
  input wire logic       TRIGGER_REQUEST_BIT_O,
  input wire logic       SEQUENCE_ABORT_BIT_O,
  input wire logic       EARLY_TRIGGER_ERROR_FLAG_O,
  input wire logic       RESTART_WHILE_BUSY_ERROR_FLAG_O,
  input wire logic       BUSY_O,
  input wire logic       ACTIVE_LIST_O,
  input wire logic       SAMPLE_START_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // a restart with no abort pending stays set for exactly two load cycles
  load_len_a: assert property ($rose(RESTART_REQUEST_BIT_O) && !SEQUENCE_ABORT_BIT_O
    |=> RESTART_REQUEST_BIT_O
    ##1 !RESTART_REQUEST_BIT_O) else $error("restart load length wrong");
  auto_trigger_request_bit_a: assert property (TRIGGER_MODE_I && $fell(RESTART_REQUEST_BIT_O)
    |-> TRIGGER_REQUEST_BIT_O ##3 SAMPLE_START_O) else $error("no automatic trigger");
  no_auto_a: assert property (!TRIGGER_MODE_I && $fell(RESTART_REQUEST_BIT_O)
    |-> !TRIGGER_REQUEST_BIT_O) else $error("restart mode made a trigger");
  early_flag_a: assert property (!TRIGGER_MODE_I && FLOW_ACCESS_CONFIG_FIELD_I[1] && BUS_TRIGGER_I
    && RESTART_REQUEST_BIT_O |=> EARLY_TRIGGER_ERROR_FLAG_O) else $error("early flag missing");
  busy_flag_a: assert property (FLOW_ACCESS_CONFIG_FIELD_I[1] && BUS_RESTART_I && BUSY_O
    && !SEQUENCE_ABORT_BIT_O && !BUS_ABORT_I |=> RESTART_WHILE_BUSY_ERROR_FLAG_O)
    else $error("busy restart flag missing");
  trigger_request_bit_lat_a: assert property ($rose(BUSY_O) |-> ##2 SAMPLE_START_O)
    else $error("trigger latency wrong");
  abort_idle_a: assert property ($fell(SEQUENCE_ABORT_BIT_O) |-> !BUSY_O)
    else $error("abort cleared while busy");
  abort_end_a: assert property ($rose(SEQUENCE_ABORT_BIT_O) |-> ##[1:16]
    !SEQUENCE_ABORT_BIT_O) else $error("abort bit stuck");
  single_buf_a: assert property (!DOUBLE_BUF_I && !$past(DOUBLE_BUF_I)
    |-> $stable(ACTIVE_LIST_O)) else $error("single buffer swapped");
endmodule // flow_chk
`default_nettype wire

//--- int_trigger_request_bit_model.sv
// internal trigger interface model: restart, then trigger after loading
// assumes the restart bit of the flow control fed back
`timescale 1ns/1ps
`default_nettype none
module int_trigger_request_bit_model (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic with_trigger_request_bit_i,
  input  wire logic restart_request_bit_i,
  output logic      restart_o,
  output logic      trigger_o
);
  initial begin
    restart_o = 1'b0;
    trigger_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        #1 restart_o = 1'b1;
        @(posedge clk_i);
        #1 restart_o = 1'b0;
        if (with_trigger_request_bit_i) begin
          @(posedge clk_i);
          #1;
          // trigger only once loading is over
          while (restart_request_bit_i !== 1'b0) begin
            @(posedge clk_i);
            #1;
          end
          trigger_o = 1'b1;
          @(posedge clk_i);
          #1 trigger_o = 1'b0;
        end
      end
    end
  end
endmodule // int_trigger_request_bit_model
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the flow control
// assumes flow_ctrl, its package, the model and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, tm, db, are, wss, stp, wtm, ia, il, ec, we, wl, go, wt;
  logic [1:0] acc, wd;
  logic [3:0] bq, wa;
  logic restart_request_bit, trg, sqa, lok, ef, bf, busy, al, ss, eol, ir, it;
  int errors, n_checks, n_ss, n_eol, cyc, ev, k, i;
  int seed = 32'h3e0b;
  flow_ctrl flow_ctrl_inst (.CLK_I(clk), .RST_I(rst), .FLOW_ACCESS_CONFIG_FIELD_I(acc), .TRIGGER_MODE_I(tm),
    .DOUBLE_BUF_I(db), .AUTO_RESTART_ENABLE_I(are), .WAIT_STOP_SELECT_I(wss),
    .STOP_MODE_I(stp), .WAIT_MODE_I(wtm), .BUS_RESTART_I(bq[0]), .BUS_TRIGGER_I(bq[1]),
    .BUS_ABORT_I(bq[2]), .BUS_LOAD_OK_I(bq[3]), .INT_RESTART_I(ir), .INT_TRIGGER_I(it),
    .INT_ABORT_I(ia), .INT_LOAD_OK_I(il), .ERR_CLEAR_I(ec), .CMD_WE_I(we),
    .CMD_WR_LIST_I(wl), .CMD_WADDR_I(wa), .CMD_WDATA_I(wd), .RESTART_REQUEST_BIT_O(restart_request_bit),
    .TRIGGER_REQUEST_BIT_O(trg), .SEQUENCE_ABORT_BIT_O(sqa), .LIST_SWAP_LOAD_OK_O(lok),
    .EARLY_TRIGGER_ERROR_FLAG_O(ef), .RESTART_WHILE_BUSY_ERROR_FLAG_O(bf), .BUSY_O(busy),
    .ACTIVE_LIST_O(al), .SAMPLE_START_O(ss), .END_OF_LIST_O(eol));
  int_trigger_request_bit_model int_trigger_request_bit_model_inst (.clk_i(clk), .go_i(go), .with_trigger_request_bit_i(wt),
    .restart_request_bit_i(restart_request_bit), .restart_o(ir), .trigger_o(it));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    n_ss += (ss === 1'b1);
    n_eol += (eol === 1'b1);
    if (cyc > 20000) begin
      errors++;
      conclude();
    end
  end
  function automatic int exp_eol(input int n);
    return n / 2;
  endfunction
  task conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task bus(input logic [3:0] b);
    bq = b;
    tick(1);
    bq = 4'h0;
  endtask
  task wcmd(input logic l, input logic [3:0] a, input logic [1:0] d);
    {we, wl, wa, wd} = {1'b1, l, a, d};
    tick(1);
    we = 1'b0;
  endtask
  task wss_t();
    for (i = 0; i < 60 && ss !== 1'b1; i++) tick(1);
    chk(ss, 1'b1);
    tick(12);
  endtask
  task go_m(input logic w);
    {go, wt} = {1'b1, w};
    tick(1);
    go = 1'b0;
    tick(1);
  endtask
  initial begin
    {tm, db, are, wss, stp, wtm, ia, il, ec, we, wl, go, wt} = '0;
    {acc, wd, bq, wa} = '0;
    rst = 1'b1;
    tick(12);
    rst = 1'b0;
    chk({restart_request_bit, trg, sqa, lok, ef, bf, busy, al, ss, eol}, 16'h0000);
    wcmd(1'b0, 4'h0, flow_ctrl_pkg::CMD_END_SEQ);
    wcmd(1'b0, 4'h1, flow_ctrl_pkg::CMD_END_WRAP);
    wcmd(1'b1, 4'h0, flow_ctrl_pkg::CMD_END_LIST);
    {acc, tm} = {flow_ctrl_pkg::ACC_BOTH, 1'b1};
    ev = 2 + ($random(seed) & 3);
    {n_ss, n_eol} = '0;
    bus(4'h1);
    wss_t();
    for (k = 1; k < ev; k++) begin
      tick($random(seed) & 7);
      bus(4'h2);
      wss_t();
    end
    chk(n_ss, ev);
    chk(n_eol, exp_eol(ev));
    bus(4'h1);
    tick(5);
    chk(busy, 1'b1);
    bus(4'h1);
    tick(1);
    chk(bf, 1'b1);
    wss_t();
    ec = 1'b1;
    tick(1);
    ec = 1'b0;
    chk(bf, 1'b0);
    bus(4'h2);
    tick(3);
    bus(4'h4);
    chk(sqa, 1'b1);
    for (i = 0; i < 30 && sqa !== 1'b0; i++) tick(1);
    chk({sqa, busy}, 2'b00);
    tm = 1'b0;
    bus(4'h1);
    bus(4'h2);
    chk(ef, 1'b1);
    tick(4);
    chk({restart_request_bit, trg, busy}, 3'b000);
    go_m(1'b1);
    wss_t();
    acc = flow_ctrl_pkg::ACC_INTERNAL;
    bus(4'h1);
    chk(restart_request_bit, 1'b0);
    go_m(1'b0);
    chk(restart_request_bit, 1'b1);
    acc = flow_ctrl_pkg::ACC_NONE;
    tick(8);
    go_m(1'b0);
    chk(restart_request_bit, 1'b0);
    {acc, tm, db} = {flow_ctrl_pkg::ACC_BUS, 2'b11};
    bus(4'h9);
    wss_t();
    chk(al, 1'b1);
    db = 1'b0;
    bus(4'h9);
    wss_t();
    chk(al, 1'b1);
    are = 1'b1;
    for (k = 0; k < 2; k++) begin
      {stp, wtm, wss} = k ? 3'b011 : 3'b100; // idle at sequence end
      tick(10);
      {stp, wtm} = 2'b00;
      for (i = 0; i < 30 && restart_request_bit !== 1'b1; i++) tick(1);
      chk(restart_request_bit, 1'b1);
      wss_t();
    end
    conclude();
  end
endmodule // tb_top
bind flow_ctrl flow_chk flow_chk_inst (.CLK_I(CLK_I), .RST_I(RST_I), .FLOW_ACCESS_CONFIG_FIELD_I(FLOW_ACCESS_CONFIG_FIELD_I),
    .TRIGGER_MODE_I(TRIGGER_MODE_I), .DOUBLE_BUF_I(DOUBLE_BUF_I),
    .BUS_RESTART_I(BUS_RESTART_I), .BUS_TRIGGER_I(BUS_TRIGGER_I), .BUS_ABORT_I(BUS_ABORT_I),
    .RESTART_REQUEST_BIT_O(RESTART_REQUEST_BIT_O), .TRIGGER_REQUEST_BIT_O(TRIGGER_REQUEST_BIT_O),
    .SEQUENCE_ABORT_BIT_O(SEQUENCE_ABORT_BIT_O), .BUSY_O(BUSY_O), .ACTIVE_LIST_O(ACTIVE_LIST_O),
    .EARLY_TRIGGER_ERROR_FLAG_O(EARLY_TRIGGER_ERROR_FLAG_O), .SAMPLE_START_O(SAMPLE_START_O),
    .RESTART_WHILE_BUSY_ERROR_FLAG_O(RESTART_WHILE_BUSY_ERROR_FLAG_O));
`default_nettype wire
